/* acs_pkg.sv */
/*
 * acs_pkg: constants shared by the converter sequencer and its clock divider.
 * Assumes a 10 MHz system clock; the RC start delay is counted in system clock cycles, acquisition, conversion and gap in conversion clock periods.
 */
// Operation
// - with internal RC clock chosen, wait one instruction cycle before conversion clock runs.
// - software picks reference: supply rails or two external reference pins.
// - result formed by successive approximation on the held sample.
// - device reset clears control state, turns converter off, aborts conversion.
// - on completion load result, clear start/done, set complete flag together.
// - result pair unchanged by ordinary reset; undefined after power-on or brownout.
// - wait at least two conversion clock periods before next acquisition.
// - nonzero acquisition field samples 2 to 20 periods then converts.
// - zero acquisition field converts immediately on start.
// - acquisition field resets to zero, manual mode.
// - after every conversion return to sampling selected channel.
// - no status separates acquisition from conversion; start/done stays set.
// - holding capacitor disconnected from input for whole conversion.
// - each conversion takes 13 conversion clock periods.
// - clearing start/done mid-conversion aborts; result keeps previous value.
// - field codes 7..1 give 20,16,12,8,6,4,2 periods; 0 manual.
package acs_pkg;
  localparam int RES_BITS = 12;
  localparam logic [4:0] CONV_PERIODS = 5'h0D;
  localparam logic [4:0] GAP_PERIODS = 5'h02;
  // ------------------------------------------------------------
  // clock select codes (low two bits 11 pick the internal RC clock)
  // ------------------------------------------------------------
  localparam logic [1:0] CS_RC = 2'h3;
  localparam int SYS_CLK_NS = 100;
  localparam int INSTR_CYCLE_NS = 400;
  localparam int INSTR_CYCLES = (INSTR_CYCLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [2:0] ACQ_MANUAL = 3'h0;
  typedef enum {ACS_IDLE, ACS_START_DLY, ACS_ACQ, ACS_CONV, ACS_GAP} acs_state_t;

  function automatic logic [4:0] acq_periods(input logic [2:0] f);
    case (f)
      3'h7: acq_periods = 5'h14;
      3'h6: acq_periods = 5'h10;
      3'h5: acq_periods = 5'h0C;
      3'h4: acq_periods = 5'h08;
      3'h3: acq_periods = 5'h06;
      3'h2: acq_periods = 5'h04;
      3'h1: acq_periods = 5'h02;
      default: acq_periods = 5'h00;
    endcase
  endfunction
endpackage

/* acs_tick_gen.sv */
/*
 * acs_tick_gen: one-cycle tick per conversion clock period.
 * Assumes the RC oscillator tick arrives already synchronised to clock.
 */
`timescale 1ns/1ps
module acs_tick_gen (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic rc_tick,
  output logic tick
);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [5:0] limit;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    // divider codes 000,100,001,101,010,110 -> 2,4,8,16,32,64 system clocks
    case (clk_sel)
      3'h0: limit = 6'h01;
      3'h4: limit = 6'h03;
      3'h1: limit = 6'h07;
      3'h5: limit = 6'h0F;
      3'h2: limit = 6'h1F;
      default: limit = 6'h3F;
    endcase
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!run) begin
      nxt_cnt = 6'h00;
    end else if (clk_sel[1:0] == acs_pkg::CS_RC) begin
      nxt_tick = rc_tick;
    end else if (cnt_ff >= limit) begin
      nxt_cnt = 6'h00;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_ff <= 6'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule

/* acs_sequencer.sv */
/*
 * acs_sequencer: start/done sequencing for a 12-bit successive approximation
 * converter. Assumes the analog comparator answers within one period and that
 * the internal RC oscillator pulse is asynchronous to clock.
 */
`timescale 1ns/1ps
module acs_sequencer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pwr_reset,
  input wire logic module_on,
  input wire logic go_set,
  input wire logic go_clear,
  input wire logic [2:0] acq_time_field,
  input wire logic [2:0] conv_clk_sel,
  input wire logic ext_ref_sel,
  input wire logic flag_clear,
  input wire logic comp_in,
  input wire logic rc_osc_tick,
  output logic go_done,
  output logic conv_complete_flag,
  output logic [7:0] result_high_byte,
  output logic [7:0] result_low_byte,
  output logic [11:0] dac_code,
  output logic sample_switch,
  output logic ref_ext,
  output logic converter_on
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic comp_s1_ff, comp_s2_ff, rc_s1_ff, rc_s2_ff, rc_s3_ff;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      comp_s1_ff <= 1'b0;
      comp_s2_ff <= 1'b0;
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
    end else begin
      comp_s1_ff <= comp_in;
      comp_s2_ff <= comp_s1_ff;
      rc_s1_ff <= rc_osc_tick;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
    end
  end
  logic rc_edge;
  assign rc_edge = rc_s2_ff & ~rc_s3_ff;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  acs_pkg::acs_state_t state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [3:0] bit_ff, nxt_bit;
  logic [11:0] sar_ff, nxt_sar;
  logic [11:0] res_ff, nxt_res;
  logic go_ff, nxt_go, flag_ff, nxt_flag, samp_ff, nxt_samp;
  logic ref_ff, on_ff;
  // registered copy of the acquisition field so it has a defined reset value
  logic [2:0] acq_ff, nxt_acq;
  logic [11:0] dac_ff, nxt_dac;
  logic tick, tick_run;

  assign tick_run = (state_ff != acs_pkg::ACS_IDLE) && (state_ff != acs_pkg::ACS_START_DLY);

  acs_tick_gen u_tick (
    .clock(clock),
    .rst_b(rst_b),
    .run(tick_run),
    .clk_sel(conv_clk_sel),
    .rc_tick(rc_edge),
    .tick(tick)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_sar = sar_ff;
    nxt_res = res_ff;
    nxt_go = go_ff;
    nxt_flag = flag_ff;
    nxt_samp = samp_ff;
    nxt_dac = dac_ff;
    nxt_acq = acq_time_field;
    if (flag_clear) begin
      nxt_flag = 1'b0;
    end
    case (state_ff)
      acs_pkg::ACS_IDLE: begin
        nxt_samp = module_on;
        if (go_set && module_on) begin
          nxt_go = 1'b1;
          nxt_cnt = 5'h00;
          if (conv_clk_sel[1:0] == acs_pkg::CS_RC) begin
            nxt_state = acs_pkg::ACS_START_DLY;
          end else if (acq_time_field == acs_pkg::ACQ_MANUAL) begin
            nxt_state = acs_pkg::ACS_CONV;
            nxt_samp = 1'b0;
            nxt_bit = 4'h0;
            nxt_sar = 12'h000;
          end else begin
            nxt_state = acs_pkg::ACS_ACQ;
          end
        end
      end
      acs_pkg::ACS_START_DLY: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff >= 5'(acs_pkg::INSTR_CYCLES - 1)) begin
          nxt_cnt = 5'h00;
          if (acq_ff == acs_pkg::ACQ_MANUAL) begin
            nxt_state = acs_pkg::ACS_CONV;
            nxt_samp = 1'b0;
            nxt_bit = 4'h0;
            nxt_sar = 12'h000;
          end else begin
            nxt_state = acs_pkg::ACS_ACQ;
          end
        end
      end
      acs_pkg::ACS_ACQ: begin
        if (tick) begin
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff + 5'h01 >= acs_pkg::acq_periods(acq_ff)) begin
            nxt_state = acs_pkg::ACS_CONV;
            nxt_samp = 1'b0;
            nxt_cnt = 5'h00;
            nxt_bit = 4'h0;
            nxt_sar = 12'h000;
          end
        end
      end
      acs_pkg::ACS_CONV: begin
        // period 0 is the hold settle; periods 1..12 each resolve one bit, msb first
        if (tick) begin
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff != 5'h00 && bit_ff < 4'(acs_pkg::RES_BITS)) begin
            nxt_sar[11 - bit_ff] = comp_s2_ff;
            nxt_bit = bit_ff + 4'h1;
          end
          if (cnt_ff + 5'h01 >= acs_pkg::CONV_PERIODS) begin
            nxt_res = nxt_sar;
            nxt_go = 1'b0;
            nxt_flag = 1'b1; // set wins over clear
            nxt_state = acs_pkg::ACS_GAP;
            nxt_cnt = 5'h00;
          end
        end
        nxt_dac = nxt_sar;
        // trial bit follows the bit about to be resolved, so no stale trial lingers
        if (nxt_bit < 4'(acs_pkg::RES_BITS)) begin
          nxt_dac[11 - nxt_bit] = 1'b1;
        end
      end
      acs_pkg::ACS_GAP: begin
        if (tick) begin
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff + 5'h01 >= acs_pkg::GAP_PERIODS) begin
            nxt_state = acs_pkg::ACS_IDLE;
            nxt_samp = module_on;
          end
        end
      end
      default: nxt_state = acs_pkg::ACS_IDLE;
    endcase
    // software clear or power-off aborts; result is left untouched
    if ((go_clear || !module_on) && state_ff != acs_pkg::ACS_IDLE
        && state_ff != acs_pkg::ACS_GAP) begin
      nxt_go = 1'b0;
      nxt_res = res_ff;
      nxt_flag = flag_clear ? 1'b0 : flag_ff;
      nxt_samp = 1'b0;
      nxt_state = acs_pkg::ACS_GAP;
      nxt_cnt = 5'h00;
    end
    if (nxt_state != acs_pkg::ACS_CONV) begin
      nxt_dac = 12'h000;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_ff <= acs_pkg::ACS_IDLE;
      cnt_ff <= 5'h00;
      bit_ff <= 4'h0;
      sar_ff <= 12'h000;
      go_ff <= 1'b0;
      flag_ff <= 1'b0;
      samp_ff <= 1'b0;
      dac_ff <= 12'h000;
      ref_ff <= 1'b0;
      on_ff <= 1'b0;
      acq_ff <= acs_pkg::ACQ_MANUAL;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sar_ff <= nxt_sar;
      go_ff <= nxt_go;
      flag_ff <= nxt_flag;
      samp_ff <= nxt_samp;
      dac_ff <= nxt_dac;
      ref_ff <= ext_ref_sel;
      on_ff <= module_on;
      acq_ff <= nxt_acq;
    end
  end

  // result pair survives ordinary reset; only power-on or brownout clears it
  always_ff @(posedge clock) begin
    if (pwr_reset) begin
      res_ff <= 12'h000;
    end else begin
      res_ff <= nxt_res;
    end
  end

  assign go_done = go_ff;
  assign conv_complete_flag = flag_ff;
  assign result_high_byte = {4'h0, res_ff[11:8]};
  assign result_low_byte = res_ff[7:0];
  assign dac_code = dac_ff;
  assign sample_switch = samp_ff;
  assign ref_ext = ref_ff;
  assign converter_on = on_ff;
endmodule

/* acs_sva.sv */
/* acs_sva: port checker for acs_sequencer.
   bound into every acs_sequencer; single clock domain. */
`timescale 1ns/1ps
module acs_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic go_set,
  input wire logic module_on,
  input wire logic [2:0] acq_time_field,
  input wire logic [2:0] conv_clk_sel,
  input wire logic go_done,
  input wire logic conv_complete_flag,
  input wire logic [11:0] dac_code,
  input wire logic sample_switch
);
  // conversion length counter; cycles with the hold cap cut off
  logic [6:0] run_ff;
  logic [6:0] nxt_run;
  always_comb nxt_run = (go_done && !sample_switch) ? run_ff + 7'h01 : 7'h00;
  always_ff @(posedge clock) run_ff <= nxt_run;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  rst_clear_a: assert property (disable iff (1'b0)
    !rst_b |=> !go_done && !conv_complete_flag && !sample_switch) else $error("reset not clean");
  go_accept_a: assert property (
    go_set && module_on && sample_switch && !go_done |=> go_done) else $error("start lost");
  manual_conv_a: assert property (
    $rose(go_done) && acq_time_field == 3'h0 && conv_clk_sel[1:0] != 2'h3 |-> !sample_switch)
    else $error("manual start still sampling");
  acq_sample_a: assert property (
    $rose(go_done) && acq_time_field != 3'h0 |-> sample_switch) else $error("acq skipped");
  cap_open_a: assert property (
    go_done && !sample_switch |=> !sample_switch) else $error("cap reconnected");
  done_flag_a: assert property (
    $rose(conv_complete_flag) |-> $fell(go_done)) else $error("flag without done");
  conv_len_a: assert property (
    $rose(conv_complete_flag) && conv_clk_sel == 3'h1 |-> run_ff inside {[7'h66:7'h6A]})
    else $error("conversion length wrong");
  gap_wait_a: assert property (
    $fell(go_done) && conv_clk_sel == 3'h1 |-> !sample_switch [*8]) else $error("gap short");
  idle_dac_a: assert property (
    sample_switch |-> dac_code == 12'h000) else $error("dac active while sampling");
endmodule
bind acs_sequencer acs_sva chk_u (.clock, .rst_b, .go_set, .module_on, .acq_time_field,
  .conv_clk_sel, .go_done, .conv_complete_flag, .dac_code, .sample_switch);

/* adc_acquire_convert_sequencer_test.sv */
/* testbench for acs_sequencer: conversions, aborts, resets.
   assumes the comparator model below stands in for the analog side. */
`timescale 1ns/1ps
module adc_acquire_convert_sequencer_test;
  logic clock = 1'b0, rst_b = 1'b0, pwr_reset = 1'b0, module_on = 1'b0;
  logic go_set = 1'b0, go_clear = 1'b0, ext_ref_sel = 1'b0, flag_clear = 1'b0;
  logic comp_in = 1'b0, rc_osc_tick = 1'b0;
  logic [2:0] acq_time_field = 3'h0, conv_clk_sel = 3'h1;
  logic go_done, conv_complete_flag, sample_switch, ref_ext, converter_on;
  logic [7:0] result_high_byte, result_low_byte;
  logic [11:0] dac_code, target = 12'h000;
  int failures = 0, n_checks = 0, cyc = 0, n;
  int pv[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  acs_sequencer dut_u (.clock, .rst_b, .pwr_reset, .module_on, .go_set, .go_clear,
    .acq_time_field, .conv_clk_sel, .ext_ref_sel, .flag_clear, .comp_in, .rc_osc_tick,
    .go_done, .conv_complete_flag, .result_high_byte, .result_low_byte, .dac_code,
    .sample_switch, .ref_ext, .converter_on);
  always #50 clock = ~clock;
  // keep trial bit while the held input is at or above the trial code
  always @(negedge clock) comp_in <= (dac_code <= target);
  always @(negedge clock) if (cyc % 6 == 0) rc_osc_tick <= ~rc_osc_tick;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      finish_test();
    end
  end
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task wait_ss(input logic v);
    n = 0;
    while (sample_switch !== v && n < 400) begin
      tick(1);
      n++;
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // -------------------------------------------------
  // one conversion: start, acquisition length, result, gap
  // -------------------------------------------------
  task convert(input logic [11:0] t, input logic [2:0] f, input int lo, input int hi);
    target = t;
    acq_time_field = f;
    pulse(go_set);
    chk("go_done", 1, go_done);
    wait_ss(1'b0);
    chk("acq_len", 1, n >= lo && n <= hi);
    n = 0;
    while (go_done !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    chk("flag", 1, conv_complete_flag);
    chk("result", {4'h0, t}, {result_high_byte, result_low_byte});
    pulse(go_set);
    tick(1);
    chk("gap_start", 0, go_done);
    wait_ss(1'b1);
    if (conv_clk_sel == 3'h1) chk("gap_len", 1, n >= 11 && n <= 17);
    pulse(flag_clear);
    chk("flag_clr", 0, conv_complete_flag);
  endtask
  initial begin
    tick(6);
    rst_b = 1'b1;
    chk("rst_done", 0, {go_done, conv_complete_flag, converter_on});
    module_on = 1'b1;
    ext_ref_sel = 1'b1;
    tick(4);
    chk("ref_ext", 1, ref_ext);
    chk("conv_on", 1, converter_on);
    foreach (pv[i]) convert(12'(12'hA5C ^ (12'h3F1 * i)), 3'(i), pv[i] * 8 - 3, pv[i] * 8 + 3);
    convert(12'hFFF, 3'h0, 0, 0);
    convert(12'h000, 3'h0, 0, 0);
    // abort during a programmed acquisition must stop sampling for the gap
    acq_time_field = 3'h7;
    pulse(go_set);
    tick(10);
    pulse(go_clear);
    chk("acq_abort", 0, {go_done, sample_switch});
    wait_ss(1'b1);
    acq_time_field = 3'h0;
    tick(4);
    target = 12'h123;
    pulse(go_set);
    tick(40);
    pulse(go_clear);
    chk("abort", 0, {go_done, conv_complete_flag});
    wait_ss(1'b1);
    // look after an unaborted conversion would have finished
    tick(60);
    chk("abort_res", 16'h0000, {result_high_byte, result_low_byte});
    module_on = 1'b0;
    tick(2);
    pulse(go_set);
    tick(2);
    chk("off_start", 0, {go_done, converter_on});
    module_on = 1'b1;
    tick(4);
    conv_clk_sel = 3'h3;
    convert(12'h7E1, 3'h0, 3, 40);
    conv_clk_sel = 3'h1;
    pulse(go_set);
    tick(20);
    rst_b = 1'b0;
    tick(2);
    chk("rst_abort", 0, {go_done, converter_on});
    rst_b = 1'b1;
    tick(2);
    chk("rst_keep", 16'h07E1, {result_high_byte, result_low_byte});
    pwr_reset = 1'b1;
    tick(2);
    pwr_reset = 1'b0;
    chk("por_res", 0, {result_high_byte, result_low_byte});
    finish_test();
  end
endmodule
